// *** verilog/tic_irq_ctrl.sv ***
// two-level interrupt controller core
module tic_irq_ctrl
	import tic_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             ext0_irq_input_n,
	input  wire logic             ext1_irq_input_n,
	input  wire logic             tmr0_ovf_evt,
	input  wire logic             tmr1_ovf_evt,
	input  wire logic             tmr2_ovf_evt,
	input  wire logic             tmr2_capt_evt,
	input  wire logic             serial_rx_evt,
	input  wire logic             serial_tx_evt,
	input  wire logic             conv_done_evt,
	input  wire logic             twi1_status_evt,
	input  wire logic             twi2_status_evt,
	input  wire logic             wdog_timeout_evt,
	input  wire logic [NFLAG-1:0] flag_set,
	input  wire logic [NFLAG-1:0] flag_clr,
	input  wire logic             enable_we,
	input  wire logic [NSRC-1:0]  enable_wdata,
	input  wire logic             global_we,
	input  wire logic             global_wdata,
	input  wire logic             prio_we,
	input  wire logic [NSRC-1:0]  prio_wdata,
	input  wire logic             trig_we,
	input  wire logic [1:0]       trig_wdata,
	input  wire logic             irq_ack,
	input  wire logic             irq_reti,
	input  wire logic             idle_enter,
	output logic      [NFLAG-1:0] flags_q,
	output logic      [NSRC-1:0]  irq_enable_q,
	output logic                  global_irq_enable_q,
	output logic      [NSRC-1:0]  prio_q,
	output logic                  ext0_trigger_select_q,
	output logic                  ext1_trigger_select_q,
	output logic                  irq_req_q,
	output tic_src_t              irq_src_q,
	output tic_vec_t              irq_vector_q,
	output logic                  in_svc_hi_q,
	output logic                  in_svc_lo_q,
	output logic                  idle_q
);
	import tic_pkg::*;

	logic [MC_W-1:0]  mc_cnt_q;
	logic             mc_en_q;
	logic             ext0_fall;
	logic             ext0_low;
	logic             ext1_fall;
	logic             ext1_low;
	logic [NFLAG-1:0] hw_set;
	logic [NFLAG-1:0] hw_clr;
	logic [NSRC-1:0]  src_req;
	logic [NSRC-1:0]  active;
	logic             hi_hit;
	logic             lo_hit;
	tic_src_t         hi_src;
	tic_src_t         lo_src;
	logic             win_valid;
	tic_src_t         win_src;

	// machine cycle enable
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mc_cnt_q <= MC_ZERO;
			mc_en_q  <= 1'b0;
		end else begin
			mc_cnt_q <= (mc_cnt_q == MC_LAST) ? MC_ZERO : mc_cnt_q + 1'b1;
			mc_en_q  <= (mc_cnt_q == MC_LAST);
		end
	end

	tic_ext_detect u_ext0 (
		.core_clk   (core_clk),
		.rst        (rst),
		.mc_en      (mc_en_q),
		.pin_n      (ext0_irq_input_n),
		.fall_pulse (ext0_fall),
		.sample_low (ext0_low)
	);

	tic_ext_detect u_ext1 (
		.core_clk   (core_clk),
		.rst        (rst),
		.mc_en      (mc_en_q),
		.pin_n      (ext1_irq_input_n),
		.fall_pulse (ext1_fall),
		.sample_low (ext1_low)
	);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ext0_trigger_select_q <= 1'b0;
			ext1_trigger_select_q <= 1'b0;
		end else if (trig_we) begin
			ext0_trigger_select_q <= trig_wdata[0];
			ext1_trigger_select_q <= trig_wdata[1];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_enable_q        <= EN_RST;
			global_irq_enable_q <= 1'b0;
			prio_q              <= PRI_RST;
		end else begin
			if (enable_we) irq_enable_q <= enable_wdata;
			if (global_we) global_irq_enable_q <= global_wdata;
			if (prio_we) prio_q <= prio_wdata;
		end
	end

	// hardware set and clear terms; trigger select 1 is edge
	always_comb begin
		hw_set = '0;
		hw_clr = '0;
		hw_set[F_EXT0] = ext0_trigger_select_q ? ext0_fall : (mc_en_q & ext0_low);
		hw_set[F_EXT1] = ext1_trigger_select_q ? ext1_fall : (mc_en_q & ext1_low);
		hw_clr[F_EXT0] = ~ext0_trigger_select_q & mc_en_q & ~ext0_low;
		hw_clr[F_EXT1] = ~ext1_trigger_select_q & mc_en_q & ~ext1_low;
		hw_set[F_TMR0]    = tmr0_ovf_evt;
		hw_set[F_TMR1]    = tmr1_ovf_evt;
		hw_set[F_TMR2OVF] = tmr2_ovf_evt;
		hw_set[F_TMR2EVT] = tmr2_capt_evt;
		hw_set[F_RX]      = serial_rx_evt;
		hw_set[F_TX]      = serial_tx_evt;
		hw_set[F_CONV] = conv_done_evt;
		hw_set[F_TWI1] = twi1_status_evt;
		hw_set[F_TWI2] = twi2_status_evt;
		hw_set[F_WDOG] = wdog_timeout_evt;
		if (irq_ack) begin
			if (irq_src_q == SRC_EXT0 && ext0_trigger_select_q) hw_clr[F_EXT0] = 1'b1;
			if (irq_src_q == SRC_EXT1 && ext1_trigger_select_q) hw_clr[F_EXT1] = 1'b1;
			// timer 0 and 1 cleared on entry
			if (irq_src_q == SRC_TMR0) hw_clr[F_TMR0] = 1'b1;
			if (irq_src_q == SRC_TMR1) hw_clr[F_TMR1] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flags_q <= FLAGS_RST;
		end else begin
			flags_q <= (flags_q & ~(hw_clr | flag_clr)) | hw_set | flag_set;
		end
	end

	always_comb begin
		src_req[SRC_EXT0] = flags_q[F_EXT0];
		src_req[SRC_TMR0] = flags_q[F_TMR0];
		src_req[SRC_EXT1] = flags_q[F_EXT1];
		src_req[SRC_TMR1] = flags_q[F_TMR1];
		src_req[SRC_SER] = flags_q[F_RX] | flags_q[F_TX];
		// timer 2 or of two flags
		src_req[SRC_TMR2] = flags_q[F_TMR2OVF] | flags_q[F_TMR2EVT];
		src_req[SRC_CONV] = flags_q[F_CONV];
		src_req[SRC_TWI1] = flags_q[F_TWI1];
		src_req[SRC_TWI2] = flags_q[F_TWI2];
		src_req[SRC_WDOG] = flags_q[F_WDOG];
		active = src_req & irq_enable_q & {NSRC{global_irq_enable_q}};
	end

	always_comb begin
		hi_hit = 1'b0;
		lo_hit = 1'b0;
		hi_src = SRC_EXT0;
		lo_src = SRC_EXT0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (active[i] && prio_q[i]) begin
				hi_hit = 1'b1;
				hi_src = tic_src_t'(i);
			end
			if (active[i] && !prio_q[i]) begin
				lo_hit = 1'b1;
				lo_src = tic_src_t'(i);
			end
		end
		if (in_svc_hi_q) begin
			win_valid = 1'b0;
			win_src   = hi_src;
		end else if (in_svc_lo_q || hi_hit) begin
			win_valid = hi_hit;
			win_src   = hi_src;
		end else begin
			win_valid = lo_hit;
			win_src   = lo_src;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_req_q    <= 1'b0;
			irq_src_q    <= SRC_EXT0;
			irq_vector_q <= VEC_TABLE[0];
		end else begin
			irq_req_q    <= win_valid & ~irq_ack;
			irq_src_q    <= win_src;
			irq_vector_q <= VEC_TABLE[win_src];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_svc_hi_q <= 1'b0;
			in_svc_lo_q <= 1'b0;
		end else if (irq_ack) begin
			if (prio_q[irq_src_q]) in_svc_hi_q <= 1'b1;
			else in_svc_lo_q <= 1'b1;
		end else if (irq_reti) begin
			if (in_svc_hi_q) in_svc_hi_q <= 1'b0;
			else in_svc_lo_q <= 1'b0;
		end
	end

	// wake from idle on any enabled request
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			idle_q <= 1'b0;
		end else if (|active) begin
			idle_q <= 1'b0;
		end else if (idle_enter) begin
			idle_q <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_ext0_edge_fall;
		ext0_trigger_select_q && ext0_fall;
	endsequence
	sequence s_ext0_edge_ack;
		irq_ack && irq_src_q == SRC_EXT0 && ext0_trigger_select_q && !hw_set[F_EXT0] && !flag_set[F_EXT0];
	endsequence
	sequence s_ext0_level_ack;
		irq_ack && irq_src_q == SRC_EXT0 && !ext0_trigger_select_q && !mc_en_q && !flag_clr[F_EXT0];
	endsequence

	AST_EDGE_SETS:
	assert property (s_ext0_edge_fall |=> flags_q[F_EXT0])
		else $error("edge did not set ext0 flag");
	AST_EDGE_ACK_CLEARS:
	assert property (s_ext0_edge_ack |=> !flags_q[F_EXT0])
		else $error("edge flag kept after vectoring");
	AST_LEVEL_ACK_KEEPS:
	assert property (s_ext0_level_ack and flags_q[F_EXT0] |=> flags_q[F_EXT0])
		else $error("level flag cleared on vectoring");
	AST_TMR0_ACK_CLEARS:
	assert property (irq_ack && irq_src_q == SRC_TMR0 && !tmr0_ovf_evt && !flag_set[F_TMR0]
		|=> !flags_q[F_TMR0])
		else $error("timer0 flag kept after entry");
	AST_TMR2_ACK_KEEPS:
	assert property (irq_ack && irq_src_q == SRC_TMR2 && flags_q[F_TMR2OVF] && !flag_clr[F_TMR2OVF]
		|=> flags_q[F_TMR2OVF])
		else $error("timer2 flag cleared by hardware");
	AST_SW_SET_WINS:
	assert property (flag_set[F_CONV] && flag_clr[F_CONV] |=> flags_q[F_CONV])
		else $error("software set lost");
	AST_GLOBAL_BLOCKS:
	assert property (!global_irq_enable_q |=> !irq_req_q)
		else $error("request with global enable off");
	AST_HI_BLOCKS:
	assert property (in_svc_hi_q |=> !irq_req_q)
		else $error("request during high routine");
	// vectors step by eight from ext0, watchdog stands apart
	AST_VECTOR_MATCH:
	assert property (irq_req_q |-> irq_vector_q == ((irq_src_q == SRC_WDOG) ? VEC_TABLE[SRC_WDOG]
		: (VEC_TABLE[SRC_EXT0] + {9'h000, irq_src_q, 3'h0})))
		else $error("vector does not match source");
	AST_WDOG_GATED:
	assert property (!irq_enable_q[SRC_WDOG] |=> !(irq_req_q && irq_src_q == SRC_WDOG))
		else $error("watchdog request while disabled");
	AST_IDLE_WAKE:
	assert property (idle_q && (|active) |=> !idle_q)
		else $error("idle not cleared by request");
	AST_EDGE_TO_REQ:
	assert property (s_ext0_edge_fall ##1 (global_irq_enable_q && irq_enable_q[SRC_EXT0]
		&& prio_q[SRC_EXT0] && !in_svc_hi_q && !irq_ack) |=> irq_req_q && irq_src_q == SRC_EXT0)
		else $error("enabled ext0 not requested");
endmodule : tic_irq_ctrl

// *** verilog/tic_pkg.sv ***
// constants and types of the two-level interrupt controller
// Contract
// - ten sources, each with flag, enable, priority and vector; global enable masks all
// - each external input selects edge or level triggering by its own bit
// - edge mode samples once per machine cycle; high then low sets the flag
// - edge-mode external flag is cleared by hardware when the cpu vectors
// - level mode: pin held low until serviced; flag not cleared on vectoring
// - timer 0 and 1 overflow flags request and clear on service entry
// - timer 2 request is overflow OR event flag; only software clears them
// - conversion-done flag requests when converter enable set; software clears only
// - each two-wire channel flag set on new status; software clears only
// - watchdog time-out sets its flag; interrupt only when watchdog enable set
// - every flag settable and clearable by software; software set requests alike
// - global enable cleared blocks every request
// - per-source high or low priority; fixed order resolves same-level ties
// - fixed order and vectors from ext0 0x0003 down to watchdog 0x0063
// - serial port requests when receive or transmit flag set; both software-clearable
// - in idle any enabled interrupt wakes the cpu and clears the idle bit
package tic_pkg;
	localparam int NSRC    = 10;
	localparam int NFLAG   = 12;
	localparam int MC_CLKS = 4;
	localparam int MC_W    = 2;

	typedef logic [3:0]  tic_src_t;
	typedef logic [15:0] tic_vec_t;

	localparam tic_src_t SRC_EXT0 = 4'h0;
	localparam tic_src_t SRC_TMR0 = 4'h1;
	localparam tic_src_t SRC_EXT1 = 4'h2;
	localparam tic_src_t SRC_TMR1 = 4'h3;
	localparam tic_src_t SRC_SER  = 4'h4;
	localparam tic_src_t SRC_TMR2 = 4'h5;
	localparam tic_src_t SRC_CONV = 4'h6;
	localparam tic_src_t SRC_TWI1 = 4'h7;
	localparam tic_src_t SRC_TWI2 = 4'h8;
	localparam tic_src_t SRC_WDOG = 4'h9;

	localparam int F_EXT0    = 0;
	localparam int F_EXT1    = 1;
	localparam int F_TMR0    = 2;
	localparam int F_TMR1    = 3;
	localparam int F_TMR2OVF = 4;
	localparam int F_TMR2EVT = 5;
	localparam int F_RX      = 6;
	localparam int F_TX      = 7;
	localparam int F_CONV    = 8;
	localparam int F_TWI1    = 9;
	localparam int F_TWI2    = 10;
	localparam int F_WDOG    = 11;

	localparam tic_vec_t VEC_TABLE [NSRC] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
		16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h0063};

	localparam logic [NFLAG-1:0] FLAGS_RST = 12'h000;
	localparam logic [NSRC-1:0]  EN_RST    = 10'h000;
	localparam logic [NSRC-1:0]  PRI_RST   = 10'h000;
	localparam logic [MC_W-1:0]  MC_LAST   = 2'h3;
	localparam logic [MC_W-1:0]  MC_ZERO   = 2'h0;
	localparam logic [2:0]       SYNC_RST  = 3'h7;
endpackage : tic_pkg

// *** verilog/tic_ext_detect.sv ***
// external interrupt pin synchroniser and machine-cycle sampler
module tic_ext_detect
	import tic_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic mc_en,
	input  wire logic pin_n,
	output logic      fall_pulse,
	output logic      sample_low
);
	logic [2:0] sync_q;
	logic       stable_q;
	logic       prev_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_q <= SYNC_RST;
		end else begin
			sync_q <= {sync_q[1:0], pin_n};
		end
	end

	// a level change counts once two late stages agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stable_q <= 1'b1;
		end else if (sync_q[1] == sync_q[2]) begin
			stable_q <= sync_q[2];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b1;
		end else if (mc_en) begin
			prev_q <= stable_q;
		end
	end

	// relies on pin held a full cycle
	assign fall_pulse = mc_en & prev_q & ~stable_q;
	assign sample_low = ~stable_q;
endmodule : tic_ext_detect

// *** verification/tic_cpu_model.sv ***
// behavioural cpu core that vectors to and returns from service routines
module tic_cpu_model
	import tic_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [7:0] ack_dly,
	input  wire logic [7:0] svc_len,
	input  wire logic       irq_req_q,
	input  wire tic_vec_t   irq_vector_q,
	output logic            irq_ack,
	output logic            irq_reti,
	output tic_vec_t        last_vec,
	output int              n_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	int wt;
	int tmr;
	int depth;

	// inputs change at the falling edge, design samples at the rising one
	always @(negedge core_clk or posedge rst) begin
		if (rst) begin
			irq_ack  <= 1'b0;
			irq_reti <= 1'b0;
			last_vec <= '0;
			n_ack    <= 0;
			wt = 0;
			tmr = 0;
			depth = 0;
		end else begin
			irq_ack  <= 1'b0;
			irq_reti <= 1'b0;
			wt = (go && irq_req_q && !irq_ack) ? wt + 1 : 0;
			if (wt > int'(ack_dly)) begin
				irq_ack  <= 1'b1;
				last_vec <= irq_vector_q;
				n_ack    <= n_ack + 1;
				depth = depth + 1;
				tmr = int'(svc_len);
				wt = 0;
			end else if (depth > 0) begin
				if (tmr == 0) begin
					irq_reti <= 1'b1;
					depth = depth - 1;
					tmr = int'(svc_len);
				end else begin
					tmr = tmr - 1;
				end
			end
		end
	end
endmodule : tic_cpu_model

// *** verification/two_level_interrupt_controller_tb.sv ***
// self-checking bench of the interrupt controller core
module two_level_interrupt_controller_tb
	import tic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int SRC_OF [12] = '{0, 2, 1, 3, 5, 5, 4, 4, 6, 7, 8, 9};

	logic        core_clk, rst, enable_we, global_we, global_wdata, prio_we, trig_we, irq_ack, irq_reti, idle_enter, go;
	logic [11:0] evt, flag_set, flag_clr, flags_q;
	logic [9:0]  enable_wdata, prio_wdata, irq_enable_q, prio_q;
	logic [1:0]  trig_wdata, ext_n;
	logic        global_irq_enable_q, ext0_trigger_select_q, ext1_trigger_select_q, irq_req_q, in_svc_hi_q, in_svc_lo_q, idle_q;
	tic_src_t    irq_src_q;
	tic_vec_t    irq_vector_q, last_vec;
	logic [7:0]  ack_dly, svc_len;
	int          n_ack, failures, n_checks, n0, cyc;

	tic_irq_ctrl DUT (.*,
		.ext0_irq_input_n(ext_n[0]),
		.ext1_irq_input_n(ext_n[1]),
		.tmr0_ovf_evt(evt[2]),
		.tmr1_ovf_evt(evt[3]),
		.tmr2_ovf_evt(evt[4]),
		.tmr2_capt_evt(evt[5]),
		.serial_rx_evt(evt[6]),
		.serial_tx_evt(evt[7]),
		.conv_done_evt(evt[8]),
		.twi1_status_evt(evt[9]),
		.twi2_status_evt(evt[10]),
		.wdog_timeout_evt(evt[11]));

	tic_cpu_model CPU (.*);

	always #5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			stop_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask : endt

	task automatic fpulse(input logic [11:0] s, input logic [11:0] c);
		flag_set = s;
		flag_clr = c;
		tick(1);
		flag_set = '0;
		flag_clr = '0;
	endtask : fpulse

	task automatic cfg(input logic [9:0] en, input logic ga, input logic [9:0] pr, input logic [1:0] tr);
		enable_wdata = en;
		global_wdata = ga;
		prio_wdata = pr;
		trig_wdata = tr;
		{enable_we, global_we, prio_we, trig_we} = '1;
		tick(1);
		{enable_we, global_we, prio_we, trig_we} = '0;
	endtask : cfg

	task automatic waitack(input int n);
		int k;
		k = 0;
		while (n_ack == n && k < 200) begin
			tick(1);
			k++;
		end
		chk(16'(n_ack != n), 16'h1);
	endtask : waitack

	task automatic evpulse(input int i);
		evt[i] = 1'b1;
		tick(1);
		evt = '0;
	endtask : evpulse

	task automatic rst_chk();
		tick(1);
		chk(16'(flags_q), 16'h0);
		chk(16'(irq_enable_q), 16'h0);
		chk(16'({global_irq_enable_q, prio_q, irq_req_q}), 16'h0);
		chk(irq_vector_q, 16'h0003);
	endtask : rst_chk

	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		ext_n = 2'b11;
		evt = '0;
		flag_set = '0;
		flag_clr = '0;
		{enable_we, global_we, prio_we, trig_we, idle_enter, go} = '0;
		{enable_wdata, prio_wdata, trig_wdata, global_wdata} = '0;
		ack_dly = 8'h0;
		svc_len = 8'h14;
		tick(16);
		rst = 1'b0;
		rst_chk();
		endt("reset");
		cfg(10'h3ff, 1'b1, 10'h0, 2'b00);
		chk(16'({global_irq_enable_q, irq_enable_q}), 16'h7ff);
		go = 1'b1;
		for (int i = 2; i < 12; i++) begin
			n0 = n_ack;
			ack_dly = 8'(3 * (i % 2));
			evpulse(i);
			waitack(n0);
			chk(last_vec, VEC_TABLE[SRC_OF[i]]);
			tick(2);
			chk(16'(flags_q[i]), (i < 4) ? 16'h0 : 16'h1);
			fpulse('0, 12'(1 << i));
			tick(30);
			chk(16'({flags_q, in_svc_lo_q}), 16'h0);
		end
		endt("sources");
		// ext0 high priority so the edge-to-request path is exercised
		cfg(10'h3ff, 1'b1, 10'h001, 2'b11);
		chk(16'({ext1_trigger_select_q, ext0_trigger_select_q}), 16'h3);
		chk(16'(prio_q), 16'h001);
		for (int j = 0; j < 2; j++) begin
			n0 = n_ack;
			// pin held low well over a machine cycle
			ext_n[j] = 1'b0;
			waitack(n0);
			chk(last_vec, (j == 1) ? 16'h0013 : 16'h0003);
			tick(2);
			chk(16'(flags_q[j]), 16'h0);
			tick(12);
			chk(16'(n_ack - n0), 16'h1);
			ext_n[j] = 1'b1;
			tick(30);
		end
		endt("edge");
		cfg(10'h3ff, 1'b1, 10'h0, 2'b00);
		n0 = n_ack;
		ext_n[0] = 1'b0;
		waitack(n0);
		tick(2);
		chk(16'(flags_q[0]), 16'h1);
		tick(28);
		chk(16'(n_ack - n0), 16'h2);
		ext_n[0] = 1'b1;
		tick(40);
		chk(16'(flags_q[0]), 16'h0);
		endt("level");
		cfg(10'h3ff, 1'b0, 10'h0, 2'b00);
		fpulse(12'h200, 12'h0);
		tick(5);
		chk(16'(irq_req_q), 16'h0);
		chk(16'(flags_q[9]), 16'h1);
		n0 = n_ack;
		cfg(10'h3ff, 1'b1, 10'h0, 2'b00);
		waitack(n0);
		chk(last_vec, 16'h003b);
		fpulse(12'h0, 12'h200);
		tick(30);
		cfg(10'h1ff, 1'b1, 10'h0, 2'b00);
		evpulse(11);
		tick(5);
		chk(16'(irq_req_q), 16'h0);
		chk(16'(flags_q[11]), 16'h1);
		n0 = n_ack;
		cfg(10'h3ff, 1'b1, 10'h0, 2'b00);
		waitack(n0);
		chk(last_vec, 16'h0063);
		fpulse(12'h0, 12'h800);
		tick(30);
		endt("masking");
		go = 1'b0;
		cfg(10'h3ff, 1'b1, 10'h200, 2'b00);
		chk(16'(prio_q), 16'h200);
		chk(16'({ext1_trigger_select_q, ext0_trigger_select_q}), 16'h0);
		fpulse(12'h810, 12'h0);
		tick(3);
		chk(irq_vector_q, 16'h0063);
		fpulse(12'h100, 12'h800);
		tick(3);
		chk(irq_vector_q, 16'h002b);
		chk(16'(irq_src_q), 16'h5);
		fpulse(12'h0, 12'h110);
		tick(3);
		chk(16'(irq_req_q), 16'h0);
		go = 1'b1;
		svc_len = 8'h28;
		n0 = n_ack;
		fpulse(12'h100, 12'h0);
		waitack(n0);
		chk(last_vec, 16'h0033);
		fpulse(12'h800, 12'h0);
		waitack(n0 + 1);
		chk(last_vec, 16'h0063);
		fpulse(12'h200, 12'h900);
		tick(2);
		chk(16'({in_svc_hi_q, in_svc_lo_q}), 16'h3);
		tick(20);
		chk(16'(n_ack - n0), 16'h2);
		waitack(n0 + 2);
		chk(last_vec, 16'h003b);
		fpulse(12'h0, 12'h200);
		tick(100);
		endt("priority");
		go = 1'b0;
		idle_enter = 1'b1;
		tick(1);
		idle_enter = 1'b0;
		tick(1);
		chk(16'(idle_q), 16'h1);
		fpulse(12'h100, 12'h0);
		tick(3);
		chk(16'(idle_q), 16'h0);
		fpulse(12'h0, 12'h100);
		endt("idle");
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		rst_chk();
		endt("second reset");
		stop_test();
	end
endmodule : two_level_interrupt_controller_tb
